// [design/drop_bus_line_port_mux.sv]
// Pin mux of drop bus bits 2..7 and tributary line data and clocks
`timescale 1ns/10ps
`default_nettype none
module drop_bus_line_port_mux (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dropBusEnable,
  input wire logic dropBusClock,
  input wire logic [7:0] dropData,
  input wire logic [2:0] tribLineBit,
  input wire logic [2:0] tribSts1Mode,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regIndirect,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regPage,
  input wire logic [7:0] regOffset,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic drop_bus0_clock,
  output logic drop_bus0_bit2,
  output logic drop_bus0_bit3,
  output logic drop_bus0_bit4,
  output logic drop_bus0_bit5,
  output logic drop_bus0_bit6,
  output logic drop_bus0_bit7
);
  localparam int NT = dbm_pkg::DBM_NUM_TRIB;
  localparam int IB = dbm_pkg::DBM_INVERT_BIT;

  dbm_line_if line ();

  dbm_line_clock_gen u_clk (
    .clk(clk),
    .nrst(nrst),
    .line(line.src)
  );

  // ====================================
  // Register decode
  logic [7:0] ioctl_q [NT];
  logic [7:0] ioctl_d [NT];
  logic [NT-1:0] hit;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    hit[0] = regIndirect ?
      (regPage == dbm_pkg::DBM_PAGE_CH0 &&
       regOffset == dbm_pkg::DBM_PAGE_OFFSET_IOCTL) :
      (regAddr == dbm_pkg::DBM_ADDR_IOCTL_CH0);
    hit[1] = regIndirect ?
      (regPage == dbm_pkg::DBM_PAGE_CH4 &&
       regOffset == dbm_pkg::DBM_PAGE_OFFSET_IOCTL) :
      (regAddr == dbm_pkg::DBM_ADDR_IOCTL_CH4);
    hit[2] = regIndirect ?
      (regPage == dbm_pkg::DBM_PAGE_CH8 &&
       regOffset == dbm_pkg::DBM_PAGE_OFFSET_IOCTL) :
      (regAddr == dbm_pkg::DBM_ADDR_IOCTL_CH8);
  end

  // Unmapped reads return zero; read data holds until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (regRead) begin
      rdata_d = dbm_pkg::DBM_READ_IDLE;
      for (int i = 0; i < NT; i++) begin
        if (hit[i]) begin
          rdata_d = ioctl_q[i];
        end
      end
    end
  end

  // ====================================
  // Per-tributary control and line data lane
  logic [NT-1:0] lineData_q, lineData_d;
  logic [NT-1:0] useFall;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : gTrib
      always_comb begin
        ioctl_d[g] = ioctl_q[g];
        if (regWrite && hit[g]) begin
          ioctl_d[g] = regWdata;
        end
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          ioctl_q[g] <= dbm_pkg::DBM_IOCTL_RESET;
        end else begin
          ioctl_q[g] <= ioctl_d[g];
        end
      end
      assign useFall[g] = ioctl_q[g][IB] && !tribSts1Mode[g];
      // update on chosen line clock edge
      always_comb begin
        lineData_d[g] = lineData_q[g];
        if (useFall[g] ? line.fallEvt : line.riseEvt) begin
          lineData_d[g] = tribLineBit[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineData_q <= '0;
      rdata_q <= dbm_pkg::DBM_READ_IDLE;
    end else begin
      lineData_q <= lineData_d;
      rdata_q <= rdata_d;
    end
  end

  // ====================================
  // Drop bus capture on drop clock rising edge
  logic dropClkPrev_q;
  logic [7:2] dropBits_q, dropBits_d;

  // capture bits 2..7 on rising edge
  always_comb begin
    dropBits_d = dropBits_q;
    if (dropBusClock && !dropClkPrev_q) begin
      dropBits_d = dropData[7:2];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dropClkPrev_q <= 1'b0;
      dropBits_q <= '0;
    end else begin
      dropClkPrev_q <= dropBusClock;
      dropBits_q <= dropBits_d;
    end
  end

  // ====================================
  // Output pin mux, registered
  logic [7:2] pins_d;
  logic clkOut_d;

  always_comb begin
    // Straight copy keeps the pin clock rise on the data update edge
    clkOut_d = dropBusEnable ? dropBusClock : 1'b0;
    if (dropBusEnable) begin
      pins_d = dropBits_d;
    end else begin
      pins_d[2] = lineData_d[0];
      pins_d[3] = lineData_d[1];
      pins_d[4] = lineData_d[2];
      pins_d[5] = line.lineClk;
      pins_d[6] = line.lineClk;
      pins_d[7] = line.lineClk;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      drop_bus0_clock <= 1'b0;
      {drop_bus0_bit7, drop_bus0_bit6, drop_bus0_bit5,
       drop_bus0_bit4, drop_bus0_bit3, drop_bus0_bit2} <= '0;
      regRdata <= dbm_pkg::DBM_READ_IDLE;
    end else begin
      drop_bus0_clock <= clkOut_d;
      {drop_bus0_bit7, drop_bus0_bit6, drop_bus0_bit5,
       drop_bus0_bit4, drop_bus0_bit3, drop_bus0_bit2} <= pins_d;
      regRdata <= rdata_d;
    end
  end

  // ====================================
  // Assertions
  reset_clear_a: assert property (@(posedge clk)
    $rose(nrst) |-> ioctl_q[0] == dbm_pkg::DBM_IOCTL_RESET)
    else $error("invert bits not cleared after reset");

  sequence dropRise_s;
    dropBusEnable && dropBusClock && !dropClkPrev_q;
  endsequence
  drop_clock_a: assert property (@(posedge clk) disable iff (!nrst)
    dropBusEnable |=> drop_bus0_clock == $past(dropBusClock))
    else $error("drop clock pin not in step with drop data");

  drop_update_a: assert property (@(posedge clk) disable iff (!nrst)
    dropRise_s ##1 dropBusEnable |->
      drop_bus0_bit5 == $past(dropData[5]))
    else $error("drop bit not taken on rising drop clock");

  line_data_a: assert property (@(posedge clk) disable iff (!nrst)
    !dropBusEnable && line.riseEvt && !useFall[0] |=>
      drop_bus0_bit2 == $past(tribLineBit[0]))
    else $error("channel 0 line data not on bit 2");

  line_clock_a: assert property (@(posedge clk) disable iff (!nrst)
    !dropBusEnable |=> drop_bus0_bit5 == $past(line.lineClk))
    else $error("channel 0 line clock not on bit 5");

  clk_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    !dropBusEnable |=> drop_bus0_bit6 == drop_bus0_bit5 &&
      drop_bus0_bit7 == drop_bus0_bit5)
    else $error("line clocks 4 and 8 not on bits 6 and 7");

  sts1_rise_a: assert property (@(posedge clk) disable iff (!nrst)
    tribSts1Mode[1] && line.fallEvt |=>
      lineData_q[1] == $past(lineData_q[1]))
    else $error("falling edge chosen in STS-1 mode");

  fall_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    useFall[2] && line.riseEvt |=> lineData_q[2] == $past(lineData_q[2]))
    else $error("inverted lane moved on rising edge");

  paged_write_a: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && regIndirect && regPage == dbm_pkg::DBM_PAGE_CH8 &&
    regOffset == dbm_pkg::DBM_PAGE_OFFSET_IOCTL |=>
      ioctl_q[2] == $past(regWdata))
    else $error("paged write to channel 8 lost");
endmodule
`default_nettype wire

// [design/dbm_pkg.sv]
// Package: constants and types for the drop bus line port mux
package dbm_pkg;
  // Direct register addresses of the line I/O control registers
  localparam logic [15:0] DBM_ADDR_IOCTL_CH0 = 16'h1f01;
  localparam logic [15:0] DBM_ADDR_IOCTL_CH4 = 16'h5f01;
  localparam logic [15:0] DBM_ADDR_IOCTL_CH8 = 16'h9f01;
  // Indirect page numbers and the offset within a page
  localparam logic [7:0] DBM_PAGE_CH0 = 8'h1e;
  localparam logic [7:0] DBM_PAGE_CH4 = 8'h5e;
  localparam logic [7:0] DBM_PAGE_CH8 = 8'h9e;
  localparam logic [7:0] DBM_PAGE_OFFSET_IOCTL = 8'h01;
  // Clock-invert bit position within the control register
  localparam int DBM_INVERT_BIT = 2;
  localparam logic [7:0] DBM_IOCTL_RESET = 8'h00;
  localparam int DBM_NUM_TRIB = 3;
  localparam logic [7:0] DBM_READ_IDLE = 8'h00;
  // Line clock divider: half period in system clocks
  localparam logic [3:0] DBM_LINE_HALF_PERIOD = 4'h2;
  typedef enum logic [1:0] {
    DBM_PHASE_LOW = 2'b01,
    DBM_PHASE_HIGH = 2'b10
  } dbm_phase_type;
endpackage

// [design/dbm_line_if.sv]
// Interface: line clock phase events shared with the tributary lane
`timescale 1ns/10ps
`default_nettype none
interface dbm_line_if;
  logic riseEvt;
  logic fallEvt;
  logic lineClk;
  modport src (output riseEvt, output fallEvt, output lineClk);
  modport dst (input riseEvt, input fallEvt, input lineClk);
endinterface
`default_nettype wire

// [design/dbm_line_clock_gen.sv]
// Line clock divider producing clock level and edge event pulses
`timescale 1ns/10ps
`default_nettype none
module dbm_line_clock_gen (
  input wire logic clk,
  input wire logic nrst,
  dbm_line_if.src line
);
  dbm_pkg::dbm_phase_type phase_q, phase_d;
  logic [3:0] cnt_q, cnt_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  // ====================================
  // Divider
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q + 4'h1;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (cnt_q == dbm_pkg::DBM_LINE_HALF_PERIOD - 4'h1) begin
      cnt_d = 4'h0;
      case (phase_q)
        dbm_pkg::DBM_PHASE_LOW: begin
          phase_d = dbm_pkg::DBM_PHASE_HIGH;
          rise_d = 1'b1;
        end
        dbm_pkg::DBM_PHASE_HIGH: begin
          phase_d = dbm_pkg::DBM_PHASE_LOW;
          fall_d = 1'b1;
        end
        default: begin
          phase_d = dbm_pkg::DBM_PHASE_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_q <= dbm_pkg::DBM_PHASE_LOW;
      cnt_q <= 4'h0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign line.riseEvt = rise_q;
  assign line.fallEvt = fall_q;
  assign line.lineClk = (phase_q == dbm_pkg::DBM_PHASE_HIGH);
endmodule
`default_nettype wire

// [tb/dbm_line_partner.sv]
// Line interface partner: notes the clock edge each lane's data moves on
`timescale 1ns/10ps
`default_nettype none
module dbm_line_partner (
  input wire logic clk,
  input wire logic clear,
  input wire logic [2:0] lineData,
  input wire logic [2:0] lineClk,
  output logic [2:0] onRise,
  output logic [2:0] onFall,
  output logic [2:0] noEdge
);
  logic [2:0] dataQ;
  logic [2:0] clkQ;
  // ==========================================
  // Edge tracking
  // data edge seen
  // Sampled a cycle late, so pin and clock moves line up
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (lineData[i] !== dataQ[i]) begin
        if (lineClk[i] === clkQ[i]) noEdge[i] <= 1'b1;
        else if (lineClk[i]) onRise[i] <= 1'b1;
        else onFall[i] <= 1'b1;
      end
    end
    dataQ <= lineData;
    clkQ <= lineClk;
    if (clear) begin
      onRise <= 3'h0;
      onFall <= 3'h0;
      noEdge <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// [tb/drop_bus_line_port_mux_tb_top.sv]
// Bench for the drop bus line port mux
`timescale 1ns/10ps
`default_nettype none
module drop_bus_line_port_mux_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic busEn = 1'b0;
  logic dropClk = 1'b0;
  logic [7:0] dropData = 8'h00;
  logic [2:0] lineBit = 3'h0;
  logic [2:0] sts1 = 3'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic regInd = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regPage = 8'h00;
  logic [7:0] regOffset = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic clear = 1'b0;
  logic [2:0] onRise;
  logic [2:0] onFall;
  logic [2:0] noEdge;
  wire [5:0] pinBus;
  wire dropClkOut;
  int checks = 0;
  int mismatches = 0;
  // ==========================================
  // Clock and stimulus
  always #25 clk = ~clk;
  // Upstream line bits move once per line period
  always begin
    repeat (4) @(posedge clk);
    lineBit <= ~lineBit;
  end
  drop_bus_line_port_mux u_drop_bus_line_port_mux (
    .clk(clk), .nrst(nrst), .dropBusEnable(busEn),
    .dropBusClock(dropClk), .dropData(dropData),
    .tribLineBit(lineBit), .tribSts1Mode(sts1),
    .regWrite(regWrite), .regRead(regRead), .regIndirect(regInd),
    .regAddr(regAddr), .regPage(regPage), .regOffset(regOffset),
    .regWdata(regWdata), .regRdata(regRdata), .drop_bus0_clock(dropClkOut),
    .drop_bus0_bit2(pinBus[0]), .drop_bus0_bit3(pinBus[1]),
    .drop_bus0_bit4(pinBus[2]), .drop_bus0_bit5(pinBus[3]),
    .drop_bus0_bit6(pinBus[4]), .drop_bus0_bit7(pinBus[5])
  );
  dbm_line_partner u_dbm_line_partner (
    .clk(clk), .clear(clear), .lineData(pinBus[2:0]),
    .lineClk(pinBus[5:3]), .onRise(onRise), .onFall(onFall),
    .noEdge(noEdge)
  );
  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Indirect pair rides in the address: page high, offset low
  task automatic xfer(input logic wr, input logic ind,
                      input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= wr;
    regRead <= ~wr;
    regInd <= ind;
    regAddr <= a;
    regPage <= a[15:8];
    regOffset <= a[7:0];
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic ind, input logic [15:0] a,
                    input logic [7:0] exp);
    xfer(1'b0, ind, a, 8'h00);
    chk(regRdata, exp);
  endtask
  task automatic edges(input logic [2:0] rise, input logic [2:0] fall);
    repeat (8) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk({5'h00, onRise}, {5'h00, rise});
    chk({5'h00, onFall}, {5'h00, fall});
    chk({5'h00, noEdge}, 8'h00);
  endtask
  // Byte must stand after its data moves without a clock rise
  task automatic drop(input logic [7:0] b);
    @(posedge clk);
    dropData <= b;
    dropClk <= 1'b1;
    @(posedge clk);
    #1;
    // clock pin and byte rise together
    chk({dropClkOut, pinBus, 1'b0}, {1'b1, b[7:2], 1'b0});
    repeat (2) @(posedge clk);
    dropClk <= 1'b0;
    dropData <= ~b;
    repeat (3) @(posedge clk);
    #1;
    chk({dropClkOut, pinBus, 1'b0}, {1'b0, b[7:2], 1'b0});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk({pinBus, 2'h0}, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    rd(1'b0, 16'h1f01, 8'h00);
    rd(1'b0, 16'h5f01, 8'h00);
    rd(1'b1, 16'h9e01, 8'h00);
    rd(1'b0, 16'h1f02, 8'h00);
    xfer(1'b1, 1'b0, 16'h5f01, 8'h5a);
    rd(1'b1, 16'h5e01, 8'h5a);
    xfer(1'b1, 1'b1, 16'h1e01, 8'h01);
    edges(3'h7, 3'h0);
    @(posedge clk);
    sts1 <= 3'h2;
    xfer(1'b1, 1'b0, 16'h1f01, 8'h04);
    xfer(1'b1, 1'b0, 16'h5f01, 8'h04);
    xfer(1'b1, 1'b1, 16'h9e01, 8'h04);
    rd(1'b0, 16'h9f01, 8'h04);
    edges(3'h2, 3'h5);
    @(posedge clk);
    busEn <= 1'b1;
    foreach (dropData[i]) drop(8'h1f << i);
    drop(8'ha4);
    conclude();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
